//--- hdl/ip_drive_end.sv
// Drive end: control word decode, status word, homing method 34
//
// Local design decision: the plain strobed port.
`include "ip_mode_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module ip_drive_end (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  ip_link_if.drive        link,
  input  wire logic       power_ok_i,
  input  wire logic       fault_i,
  input  wire logic       position_reached_i,
  input  wire logic       speed_zero_i,
  input  wire logic       positive_limit_switch_i,
  input  wire logic       index_pulse_i,
  input  wire logic       home_start_i,
  input  wire logic       retained_homed_i,
  output logic            servo_enable_o,
  output logic            quick_stop_o,
  output logic            pause_o,
  output logic            setpoint_valid_o,
  output logic [31:0]     setpoint_o,
  output logic            setpoint_reject_o,
  output logic            home_move_o,
  output logic            home_dir_pos_o,
  output logic            home_decel_o,
  output logic            origin_set_o,
  output logic            home_alarm_o,
  output logic            retained_homed_o
);

  // ==========================================================
  // Object registers
  ip_mode_pkg::word16_t      cw_raw_reg;
  ip_mode_pkg::word16_t      cw_eff_reg;
  logic [7:0]                mode_reg;
  logic [7:0]                method_reg;
  logic                      fault_reg;
  logic                      fault_rst_prev_reg;
  logic                      homed_reg;
  logic                      loaded_reg;
  logic                      limit_prev_reg;
  ip_mode_pkg::home_state_t  home_reg;
  ip_mode_pkg::home_state_t  home_next;

  wire wr_cw    = link.obj_wr && (link.obj_index == `OBJ_CONTROL_WORD);
  wire wr_mode  = link.obj_wr && (link.obj_index == `OBJ_OP_MODE);
  wire wr_meth  = link.obj_wr && (link.obj_index == `OBJ_HOME_METHOD);
  wire wr_clear = link.obj_wr && (link.obj_index == `OBJ_HOME_CLEAR)
                  && (link.obj_data[7:0] == `HOME_CLEAR_VALUE);

  wire [15:0] cw_in = link.obj_data[15:0] & `CW_USED_MASK;

  wire fault_rst_hold = cw_raw_reg[`CW_FAULT_RESET];
  wire fault_rst_rise = fault_rst_hold && !fault_rst_prev_reg;

  // ==========================================================
  // Drive state decode
  wire ready    = power_ok_i && !fault_reg;
  wire volt_on  = ready && cw_eff_reg[`CW_ENABLE_VOLTAGE];
  wire sw_on    = volt_on && cw_eff_reg[`CW_SWITCH_ON];
  wire qstop    = !cw_eff_reg[`CW_QUICK_STOP];
  wire enabled  = sw_on && !qstop && cw_eff_reg[`CW_OP_ENABLE];
  wire ip_mode  = (mode_reg == `OP_MODE_IP);
  wire ip_act   = ip_mode && enabled && cw_eff_reg[`CW_IP_ENABLE];
  wire paused   = cw_eff_reg[`CW_PAUSE];
  wire target   = paused ? speed_zero_i : position_reached_i;

  wire limit_rise = positive_limit_switch_i && !limit_prev_reg;
  wire home_go    = home_start_i && enabled
                    && (method_reg == `HOME_METHOD_34);
  wire home_hit   = ((home_reg == ip_mode_pkg::HOME_POS) ||
                     (home_reg == ip_mode_pkg::HOME_NEG)) &&
                    index_pulse_i && !paused;

  wire sp_take   = link.sp_valid && link.sync_pulse && ip_act && !paused;
  wire sp_reject = link.sp_valid && !sp_take;

  // ==========================================================
  // Homing sequencer
  always_comb begin
    home_next = home_reg;
    unique case (home_reg)
      ip_mode_pkg::HOME_IDLE: begin
        if (home_go) begin
          home_next = ip_mode_pkg::HOME_POS;
        end
      end
      ip_mode_pkg::HOME_POS: begin
        if (home_hit) begin
          home_next = ip_mode_pkg::HOME_IDLE;
        end else if (limit_rise) begin
          home_next = ip_mode_pkg::HOME_STOP;
        end
      end
      ip_mode_pkg::HOME_STOP: begin
        if (speed_zero_i) begin
          home_next = ip_mode_pkg::HOME_NEG;
        end
      end
      ip_mode_pkg::HOME_NEG: begin
        if (home_hit) begin
          home_next = ip_mode_pkg::HOME_IDLE;
        end else if (limit_rise) begin
          home_next = ip_mode_pkg::HOME_ABORT;
        end
      end
      ip_mode_pkg::HOME_ABORT: begin
        if (fault_rst_rise) begin
          home_next = ip_mode_pkg::HOME_IDLE;
        end
      end
      default: begin
        home_next = ip_mode_pkg::HOME_IDLE;
      end
    endcase
    if (!enabled && (home_reg != ip_mode_pkg::HOME_ABORT)) begin
      home_next = ip_mode_pkg::HOME_IDLE;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cw_raw_reg         <= 16'h0000;
      cw_eff_reg         <= 16'h0000;
      mode_reg           <= 8'h00;
      method_reg         <= 8'h00;
      fault_rst_prev_reg <= 1'b0;
      limit_prev_reg     <= 1'b0;
      home_reg           <= ip_mode_pkg::HOME_IDLE;
    end else begin
      if (wr_cw) begin
        cw_raw_reg <= cw_in;
      end
      // Commands frozen while reset bit high
      if (!fault_rst_hold) begin
        cw_eff_reg <= cw_raw_reg;
      end
      if (wr_mode && !fault_rst_hold) begin
        mode_reg <= link.obj_data[7:0];
      end
      if (wr_meth && !fault_rst_hold) begin
        method_reg <= link.obj_data[7:0];
      end
      fault_rst_prev_reg <= fault_rst_hold;
      limit_prev_reg     <= positive_limit_switch_i;
      home_reg           <= home_next;
    end
  end

  // Fault sticky; new fault wins over reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_reg <= 1'b0;
    end else if (fault_i || (home_next == ip_mode_pkg::HOME_ABORT)) begin
      fault_reg <= 1'b1;
    end else if (fault_rst_rise) begin
      fault_reg <= 1'b0;
    end
  end

  // Retained homed flag, loaded after reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      homed_reg  <= 1'b0;
      loaded_reg <= 1'b0;
    end else begin
      loaded_reg <= 1'b1;
      if (home_hit) begin
        homed_reg <= 1'b1;
      end else if (wr_clear) begin
        homed_reg <= 1'b0;
      end else if (!loaded_reg) begin
        homed_reg <= retained_homed_i;
      end else if (home_go) begin
        homed_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Outputs and status word
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      link.status_word  <= 16'h0000;
      servo_enable_o    <= 1'b0;
      quick_stop_o      <= 1'b0;
      pause_o           <= 1'b0;
      setpoint_valid_o  <= 1'b0;
      setpoint_o        <= 32'h00000000;
      setpoint_reject_o <= 1'b0;
      home_move_o       <= 1'b0;
      home_dir_pos_o    <= 1'b0;
      home_decel_o      <= 1'b0;
      origin_set_o      <= 1'b0;
      home_alarm_o      <= 1'b0;
      retained_homed_o  <= 1'b0;
    end else begin
      link.status_word <= 16'h0000;
      link.status_word[`SW_READY]           <= ready;
      link.status_word[`SW_SWITCHED_ON]     <= sw_on;
      link.status_word[`SW_OP_ENABLED]      <= enabled;
      link.status_word[`SW_FAULT]           <= fault_reg;
      link.status_word[`SW_VOLTAGE]         <= volt_on;
      link.status_word[`SW_QUICK_STOP]      <= !qstop;
      link.status_word[`SW_SWITCH_DISABLED] <= !ready;
      link.status_word[`SW_REMOTE]          <= !fault_rst_hold;
      link.status_word[`SW_TARGET]          <= target;
      link.status_word[`SW_IP_ACTIVE]       <= ip_act;
      link.status_word[`SW_HOMED]           <= homed_reg;
      servo_enable_o    <= enabled;
      quick_stop_o      <= qstop && sw_on;
      pause_o           <= paused;
      setpoint_valid_o  <= sp_take;
      if (sp_take) begin
        setpoint_o <= link.sp_data;
      end
      setpoint_reject_o <= sp_reject;
      home_move_o       <= !paused &&
                           ((home_next == ip_mode_pkg::HOME_POS) ||
                            (home_next == ip_mode_pkg::HOME_NEG));
      home_dir_pos_o    <= (home_next == ip_mode_pkg::HOME_POS);
      home_decel_o      <= (home_next == ip_mode_pkg::HOME_STOP);
      origin_set_o      <= home_hit;
      home_alarm_o      <= (home_next == ip_mode_pkg::HOME_ABORT);
      retained_homed_o  <= homed_reg;
    end
  end

endmodule
`default_nettype wire

//--- hdl/ip_host_end.sv
// Host end: command registers, object writes, sync and set-point stream
`include "ip_mode_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module ip_host_end (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  ip_link_if.host         link,
  input  wire logic [7:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic [31:0]     rdata_o
);

  // ==========================================================
  // Command registers
  ip_mode_pkg::word16_t cw_reg;
  logic [7:0]           mode_reg;
  ip_mode_pkg::word32_t sp_reg;
  logic [15:0]          period_reg;
  logic [15:0]          count_reg;
  logic [15:0]          sent_reg;

  wire wr_cw    = wr_i && (addr_i == `HREG_CONTROL);
  wire wr_mode  = wr_i && (addr_i == `HREG_MODE);
  wire wr_sp    = wr_i && (addr_i == `HREG_SETPOINT);
  wire wr_per   = wr_i && (addr_i == `HREG_SYNC_PERIOD);
  wire wr_meth  = wr_i && (addr_i == `HREG_HOME_METHOD);
  wire wr_clr   = wr_i && (addr_i == `HREG_HOME_CLEAR);
  wire any_obj  = wr_cw || wr_mode || wr_meth || wr_clr;

  wire [15:0] obj_idx = wr_cw   ? `OBJ_CONTROL_WORD :
                        wr_mode ? `OBJ_OP_MODE      :
                        wr_meth ? `OBJ_HOME_METHOD  : `OBJ_HOME_CLEAR;

  wire sync_now = (period_reg != 16'h0000) && (count_reg == 16'h0000);
  wire stream   = (mode_reg == `OP_MODE_IP) && cw_reg[`CW_IP_ENABLE];

  wire [31:0] rd_mux =
    (addr_i == `HREG_CONTROL)     ? {16'h0000, cw_reg}          :
    (addr_i == `HREG_MODE)        ? {24'h000000, mode_reg}      :
    (addr_i == `HREG_SETPOINT)    ? sp_reg                      :
    (addr_i == `HREG_SYNC_PERIOD) ? {16'h0000, period_reg}      :
    (addr_i == `HREG_STATUS)      ? {16'h0000, link.status_word} :
    (addr_i == `HREG_REJECTS)     ? {16'h0000, sent_reg}        :
                                    32'h00000000;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cw_reg         <= 16'h0000;
      mode_reg       <= 8'h00;
      sp_reg         <= 32'h00000000;
      period_reg     <= `SYNC_PERIOD_RESET;
      count_reg      <= 16'h0000;
      sent_reg       <= 16'h0000;
      rdata_o        <= 32'h00000000;
      link.obj_wr    <= 1'b0;
      link.obj_index <= 16'h0000;
      link.obj_data  <= 32'h00000000;
      link.sync_pulse <= 1'b0;
      link.sp_valid  <= 1'b0;
      link.sp_data   <= 32'h00000000;
    end else begin
      if (wr_cw) begin
        cw_reg <= wdata_i[15:0];
      end
      // Mode value forwarded as object write
      if (wr_mode) begin
        mode_reg <= wdata_i[7:0];
      end
      if (wr_sp) begin
        sp_reg <= wdata_i;
      end
      if (wr_per) begin
        period_reg <= wdata_i[15:0];
        count_reg  <= 16'h0000;
      end else if (sync_now) begin
        count_reg <= period_reg - 16'h0001;
      end else if (count_reg != 16'h0000) begin
        count_reg <= count_reg - 16'h0001;
      end
      rdata_o        <= rd_i ? rd_mux : 32'h00000000;
      link.obj_wr    <= any_obj;
      link.obj_index <= any_obj ? obj_idx : 16'h0000;
      link.obj_data  <= any_obj ? wdata_i : 32'h00000000;
      link.sync_pulse <= sync_now;
      link.sp_valid  <= sync_now && stream;
      if (sync_now && stream) begin
        link.sp_data <= sp_reg;
        sent_reg     <= sent_reg + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

//--- hdl/ip_link_if.sv
// Link carrying object writes, sync and set-points between host and drive
`timescale 1ns/10ps
`default_nettype none
interface ip_link_if;
  logic                 obj_wr;
  ip_mode_pkg::word16_t obj_index;
  ip_mode_pkg::word32_t obj_data;
  logic                 sync_pulse;
  logic                 sp_valid;
  ip_mode_pkg::word32_t sp_data;
  ip_mode_pkg::word16_t status_word;

  modport host (
    output obj_wr,
    output obj_index,
    output obj_data,
    output sync_pulse,
    output sp_valid,
    output sp_data,
    input  status_word
  );

  modport drive (
    input  obj_wr,
    input  obj_index,
    input  obj_data,
    input  sync_pulse,
    input  sp_valid,
    input  sp_data,
    output status_word
  );
endinterface
`default_nettype wire

//--- hdl/ip_mode_defines.svh
// Offsets, field positions, reset values and timing counts for the IP link
`ifndef IP_MODE_DEFINES_SVH
`define IP_MODE_DEFINES_SVH

// Object indices and written values on the link
`define OBJ_CONTROL_WORD   16'h6040
`define OBJ_STATUS_WORD    16'h6041
`define OBJ_OP_MODE        16'h6060
`define OBJ_HOME_METHOD    16'h6098
`define OBJ_HOME_CLEAR     16'h2006
`define OP_MODE_IP         8'h07
`define HOME_METHOD_34     8'h22
`define HOME_CLEAR_VALUE   8'h07

// Control word bits
`define CW_SWITCH_ON       0
`define CW_ENABLE_VOLTAGE  1
`define CW_QUICK_STOP      2
`define CW_OP_ENABLE       3
`define CW_IP_ENABLE       4
`define CW_FAULT_RESET     7
`define CW_PAUSE           8
`define CW_USED_MASK       16'h019F
`define CW_ENABLE_MASK     16'h000F

// Status word bits
`define SW_READY           0
`define SW_SWITCHED_ON     1
`define SW_OP_ENABLED      2
`define SW_FAULT           3
`define SW_VOLTAGE         4
`define SW_QUICK_STOP      5
`define SW_SWITCH_DISABLED 6
`define SW_REMOTE          9
`define SW_TARGET          10
`define SW_IP_ACTIVE       12
`define SW_HOMED           15

// Host command port byte offsets
`define HREG_CONTROL       8'h00
`define HREG_MODE          8'h04
`define HREG_SETPOINT      8'h08
`define HREG_SYNC_PERIOD   8'h0C
`define HREG_STATUS        8'h10
`define HREG_HOME_METHOD   8'h14
`define HREG_HOME_CLEAR    8'h18
`define HREG_REJECTS       8'h1C

// Timing
`define SYNC_PERIOD_RESET  16'h0FA0

`endif

//--- hdl/ip_mode_pkg.sv
// Types shared by both ends of the interpolated-position link
package ip_mode_pkg;

  typedef enum logic [2:0] {
    HOME_IDLE  = 3'b000,
    HOME_POS   = 3'b001,
    HOME_STOP  = 3'b010,
    HOME_NEG   = 3'b011,
    HOME_ABORT = 3'b100
  } home_state_t;

  typedef logic [15:0] word16_t;
  typedef logic [31:0] word32_t;

endpackage

//--- verif/ip_link_properties.sv
// Checker for the interpolated-position link between host and drive
`include "ip_mode_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module ip_link_properties (
  input wire logic                 clock_i,
  input wire logic                 rst_n_i,
  input wire logic                 obj_wr,
  input wire ip_mode_pkg::word16_t obj_index,
  input wire ip_mode_pkg::word32_t obj_data,
  input wire logic                 sync_pulse,
  input wire logic                 sp_valid,
  input wire ip_mode_pkg::word32_t sp_data,
  input wire ip_mode_pkg::word16_t status_word
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  logic [1:0] up_cnt;
  wire        settled = up_cnt == 2'h3;
  wire        cw_wr   = obj_wr && obj_index == `OBJ_CONTROL_WORD;
  wire        mode_wr = obj_wr && obj_index == `OBJ_OP_MODE;
  // Status is only meaningful from the fourth edge after reset
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) up_cnt <= 2'h0;
    else if (!settled) up_cnt <= up_cnt + 2'h1;
  end
  // ==========================================================
  // Link properties
  property p_sync_pulse; sync_pulse |=> !sync_pulse; endproperty
  a_sync_pulse: assert property (p_sync_pulse)
    else $error("sync pulse longer than one cycle");
  property p_sp_with_sync; sp_valid |-> sync_pulse; endproperty
  a_sp_with_sync: assert property (p_sp_with_sync)
    else $error("set-point sent outside sync");
  property p_hold_blocks;
    cw_wr && obj_data[7] |-> ##[1:4] !status_word[9];
  endproperty
  a_hold_blocks: assert property (p_hold_blocks)
    else $error("remote bit stays set during fault reset hold");
  property p_remote;
    cw_wr && !obj_data[7] |-> ##[1:4] status_word[9];
  endproperty
  a_remote: assert property (p_remote)
    else $error("remote bit not set after control write");
  property p_not_ready;
    settled |-> status_word[6] == !status_word[0];
  endproperty
  a_not_ready: assert property (p_not_ready)
    else $error("cannot-enable bit disagrees with ready");
  property p_fault;
    settled && status_word[3] |-> !status_word[0] && !status_word[2];
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault shown while ready or enabled");
  property p_ip_active; status_word[12] |-> status_word[2]; endproperty
  a_ip_active: assert property (p_ip_active)
    else $error("interpolation active while not enabled");
  property p_mode;
    mode_wr && obj_data[7:0] != `OP_MODE_IP && status_word[9]
      |-> ##[1:4] !status_word[12];
  endproperty
  a_mode: assert property (p_mode)
    else $error("interpolation active in another mode");
  property p_ip_gate;
    cw_wr && !obj_data[7] && obj_data[4:0] != 5'h1F
      |-> ##[1:4] !status_word[12];
  endproperty
  a_ip_gate: assert property (p_ip_gate)
    else $error("interpolation active without control bits");
  c_setpoint: cover property (sp_valid);
  c_ip_active: cover property (status_word[12]);
  c_homed: cover property (status_word[15]);
endmodule
`default_nettype wire

//--- verif/test_interp_position_mode_ctrl.sv
// Testbench joining host end and drive end over the link
`timescale 1ns/10ps
`default_nettype none
module test_interp_position_mode_ctrl;
  typedef struct {
    logic [15:0] cw; logic [7:0] mode;
    logic [15:0] mask; logic [15:0] exp; logic qs;
  } row_t;
  logic        clock_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, sp_o, v;
  logic        pwr = 1'b1, flt = 1'b0, reached = 1'b0, spd0 = 1'b0;
  logic        lim = 1'b0, idx = 1'b0, hstart = 1'b0, keep = 1'b0;
  logic        en, qs, pause, sp_v, sp_rej, move, dpos, decel, origin;
  logic        alarm, homed;
  int          fails = 0, samples_checked = 0, cycles = 0, n;
  row_t        rows [8] = '{
    '{16'h000F, 8'h07, 16'h126D, 16'h0225, 1'b0},
    '{16'h001F, 8'h07, 16'h126D, 16'h1225, 1'b0},
    '{16'h001F, 8'h01, 16'h126D, 16'h0225, 1'b0},
    '{16'h001B, 8'h07, 16'h1261, 16'h0201, 1'b1},
    '{16'hFE7F, 8'h07, 16'h126D, 16'h1225, 1'b0},
    '{16'h009F, 8'h07, 16'h1204, 16'h1004, 1'b0},
    '{16'h0080, 8'h07, 16'h1204, 16'h1004, 1'b0},
    '{16'h0000, 8'h07, 16'h1245, 16'h0201, 1'b0}};
  always #12.5 clock_i = ~clock_i;
  ip_link_if i_ip_link_if ();
  ip_host_end i_ip_host_end (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .link(i_ip_link_if), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata));
  ip_drive_end i_ip_drive_end (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .link(i_ip_link_if), .power_ok_i(pwr), .fault_i(flt),
    .position_reached_i(reached), .speed_zero_i(spd0),
    .positive_limit_switch_i(lim), .index_pulse_i(idx),
    .home_start_i(hstart), .retained_homed_i(keep),
    .servo_enable_o(en), .quick_stop_o(qs), .pause_o(pause),
    .setpoint_valid_o(sp_v), .setpoint_o(sp_o),
    .setpoint_reject_o(sp_rej), .home_move_o(move),
    .home_dir_pos_o(dpos), .home_decel_o(decel), .origin_set_o(origin),
    .home_alarm_o(alarm), .retained_homed_o(homed));
  ip_link_properties i_ip_link_properties (.clock_i(clock_i),
    .rst_n_i(rst_n_i), .obj_wr(i_ip_link_if.obj_wr),
    .obj_index(i_ip_link_if.obj_index), .obj_data(i_ip_link_if.obj_data),
    .sync_pulse(i_ip_link_if.sync_pulse),
    .sp_valid(i_ip_link_if.sp_valid), .sp_data(i_ip_link_if.sp_data),
    .status_word(i_ip_link_if.status_word));
  // ==========================================================
  // Bus cycles and checks
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clock_i) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i) begin addr <= a; rd <= 1'b1; end
    @(posedge clock_i) rd <= 1'b0;
    @(negedge clock_i) d = rdata;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic sbit(input int b, input logic e);
    repeat (6) @(posedge clock_i);
    rd_reg(8'h10, v);
    chk("status bit", v[b], e);
  endtask
  task automatic wait_on(ref logic s);
    for (n = 0; n < 60 && s !== 1'b1; n++) @(negedge clock_i);
    if (s !== 1'b1) fails++;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test;
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clock_i);
    chk("reset status", i_ip_link_if.status_word, 32'h0);
    rst_n_i <= 1'b1;
    rd_reg(8'h0C, v);
    chk("sync period", v, 32'h0000_0FA0);
    rd_reg(8'h20, v);
    chk("unmapped", v, 32'h0);
    wr_reg(8'h0C, 32'h10);
    foreach (rows[k]) begin
      wr_reg(8'h04, {24'h0, rows[k].mode});
      wr_reg(8'h00, {16'h0, rows[k].cw});
      repeat (6) @(posedge clock_i);
      rd_reg(8'h10, v);
      chk("status", v[15:0] & rows[k].mask, rows[k].exp);
      chk("quick stop", qs, rows[k].qs);
    end
    wr_reg(8'h08, 32'h0001_2345);
    wr_reg(8'h00, 32'h1F);
    wait_on(sp_v);
    chk("setpoint", sp_o, 32'h0001_2345);
    wr_reg(8'h00, 32'h11F);
    wr_reg(8'h08, 32'h55);
    wait_on(sp_rej);
    chk("reject", sp_rej, 1'b1);
    chk("pause", pause, 1'b1);
    @(posedge clock_i) spd0 <= 1'b1;
    sbit(10, 1'b1);
    @(posedge clock_i) spd0 <= 1'b0;
    sbit(10, 1'b0);
    wr_reg(8'h00, 32'h1F);
    @(posedge clock_i) reached <= 1'b1;
    sbit(10, 1'b1);
    @(posedge clock_i) flt <= 1'b1;
    sbit(3, 1'b1);
    sbit(6, 1'b1);
    @(posedge clock_i) flt <= 1'b0;
    wr_reg(8'h00, 32'h80);
    wr_reg(8'h00, 32'h00);
    sbit(3, 1'b0);
    sbit(0, 1'b1);
    wr_reg(8'h14, 32'h22);
    wr_reg(8'h00, 32'h0F);
    sbit(2, 1'b1);
    chk("enabled", en, 1'b1);
    for (int pass = 0; pass < 2; pass++) begin
      @(posedge clock_i) hstart <= 1'b1;
      @(posedge clock_i) hstart <= 1'b0;
      repeat (3) @(negedge clock_i);
      chk("home dir", {move, dpos}, 2'b11);
      if (pass == 0) begin
        @(posedge clock_i) idx <= 1'b1;
        @(posedge clock_i) idx <= 1'b0;
        wait_on(origin);
        chk("origin", origin, 1'b1);
        sbit(15, 1'b1);
        chk("retained", homed, 1'b1);
        wr_reg(8'h18, 32'h07);
        sbit(15, 1'b0);
      end
    end
    @(posedge clock_i) lim <= 1'b1;
    repeat (3) @(negedge clock_i);
    chk("decel", decel, 1'b1);
    @(posedge clock_i) begin lim <= 1'b0; spd0 <= 1'b1; end
    repeat (3) @(negedge clock_i);
    chk("reverse", {move, dpos}, 2'b10);
    @(posedge clock_i) spd0 <= 1'b0;
    @(posedge clock_i) lim <= 1'b1;
    repeat (3) @(negedge clock_i);
    chk("alarm", alarm, 1'b1);
    sbit(3, 1'b1);
    // Reset cycle with a stored homed flag
    @(posedge clock_i) begin keep <= 1'b1; rst_n_i <= 1'b0; end
    repeat (4) @(posedge clock_i);
    rst_n_i <= 1'b1;
    sbit(15, 1'b1);
    chk("retained after reset", homed, 1'b1);
    end_of_test;
  end
endmodule
`default_nettype wire
